// *** rail_pressure_pkg.sv ***
// package: types and constants for the rail pressure loop controller
// Summary of operation
// [R1] only one valve loop runs at once
// [R2] inlet mode: relief valve gets fixed duty
// [R3] relief mode: inlet valve gets fixed duty
// [R4] feedback from selected analog input, none allowed
// [R5] over-pressure turns all valve channels off
// [R6] over-pressure flag is sticky until cleared
// [R7] clear request resets flag after condition gone
// [R8] duty capped so coil current stays under 3A
// [R9] locking pairs channel 1-2 and 3-4
// [R10] inlet drive enable gates inlet channels
// [R11] each valve has its own pwm frequency
// [R12] zero gain zeroes all three loop terms
// [R13] negative gain reverses output against error
// [R14] zero integral time disables integral term
// [R15] integral time never programmed negative
// [R16] loop terms reported as separate status values
// [R17] module present needs insertion and power
// [R18] feedback arrives already scaled in pressure units
// [R19] loop output clamped, then feed forward added
// [R20] smaller of user max and current cap wins
// [R21] manual override drives constant manual duty
// [R22] loop evaluated once per fixed sample period
package rail_pressure_pkg;
  localparam int unsigned CLK_HZ         = 250_000_000;
  localparam int unsigned SAMPLE_TIME_US = 1000;
  localparam int unsigned SAMPLE_CYCLES  = CLK_HZ / 1_000_000 * SAMPLE_TIME_US;
  // duty in 0.1 % steps
  localparam int unsigned DUTY_FULL      = 1000;
  localparam int unsigned PWM_STEP       = CLK_HZ / DUTY_FULL;
  localparam int unsigned CURRENT_MAX_MA = 3000;
  // gains are q8.8
  localparam int unsigned GAIN_FRAC      = 8;
  localparam int unsigned VALVES         = 2;
  localparam int unsigned INLET          = 0;
  localparam int unsigned RELIEF         = 1;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_AI0,
    SEL_AI1,
    SEL_AI2,
    SEL_AI3
  } pressure_sel_t;

  typedef enum logic {
    INLET_LOOP_MODE,
    RELIEF_LOOP_MODE
  } loop_target_t;

  typedef struct packed {
    logic [15:0]        pwm_freq;
    logic signed [15:0] prop_gain;
    logic [15:0]        integral_time;
    logic [15:0]        deriv_time;
    logic signed [15:0] loop_out_max;
    logic signed [15:0] loop_out_min;
    logic signed [15:0] feed_forward;
    logic [15:0]        non_loop_duty;
    logic               manual_override;
    logic [15:0]        manual_duty;
    logic [15:0]        user_max_duty;
    logic [15:0]        coil_resist_mohm;
  } valve_cfg_t;

  typedef struct packed {
    logic signed [31:0] prop_term;
    logic signed [31:0] integ_term;
    logic signed [31:0] deriv_term;
    logic [15:0]        duty;
    logic [15:0]        cap_duty;
  } valve_stat_t;
endpackage

// *** rail_pressure_loop_ctrl.sv ***
// rail pressure loop: feedback select, valve loops, current cap, pwm drive, trip
module rail_pressure_loop_ctrl #(
  parameter int unsigned SAMPLE_CYCLES_P = rail_pressure_pkg::SAMPLE_CYCLES
) (
  input  wire logic                             clock_i,
  input  wire logic                             srst_i,
  input  wire logic                             ce_i,
  input  wire logic signed [15:0]               analog_in_i [4],
  input  wire rail_pressure_pkg::pressure_sel_t pressure_input_select_i,
  input  wire logic signed [15:0]               pressure_target_i,
  input  wire logic signed [15:0]               overpressure_limit_i,
  input  wire logic                             overpressure_clear_i,
  input  wire rail_pressure_pkg::loop_target_t  loop_target_select_i,
  input  wire rail_pressure_pkg::valve_cfg_t    valve_cfg_i [rail_pressure_pkg::VALVES],
  input  wire logic [15:0]                      supply_voltage_meas_i,
  input  wire logic                             inlet_valve_drive_enable_i,
  input  wire logic                             relief_valve_drive_enable_i,
  input  wire logic                             channel_lock_i,
  input  wire logic                             module_inserted_i,
  input  wire logic                             module_powered_i,
  output logic [3:0]                            low_side_o,
  output logic                                  overpressure_fault_o,
  output logic                                  driver_module_present_o,
  output logic signed [15:0]                    pressure_feedback_o,
  output rail_pressure_pkg::valve_stat_t        valve_stat_o [rail_pressure_pkg::VALVES]
);
  import rail_pressure_pkg::*;

  localparam int TICK_W = $clog2(SAMPLE_CYCLES_P + 1);

  logic [TICK_W-1:0]  tick_cnt;
  logic               ins_meta;
  logic               ins_sync;
  logic               pwr_meta;
  logic               pwr_sync;
  wire [1:0]          ch_drive;
  logic [3:0]         next_low_side;
  wire                tick;
  wire                fb_valid;
  wire [1:0]          fb_index;
  wire signed [15:0]  fb_value;
  wire                over_limit;
  wire [1:0]          drive_en;
  wire [1:0]          gated;

  // sample period strobe, see R22
  assign tick = (tick_cnt == TICK_W'(SAMPLE_CYCLES_P - 1));

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      tick_cnt <= '0;
    end else if (ce_i) begin
      tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
    end
  end

  // feedback mux; none leaves the loops idle, see R4
  assign fb_valid = pressure_input_select_i inside {SEL_AI0, SEL_AI1, SEL_AI2, SEL_AI3};
  assign fb_index = 2'(3'(pressure_input_select_i) - 3'h1);
  assign fb_value = fb_valid ? analog_in_i[fb_index] : 16'sh0000;

  // inputs taken as already in pressure units, see R18
  assign over_limit = fb_valid && (fb_value > overpressure_limit_i);

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ins_meta                <= 1'b0;
      ins_sync                <= 1'b0;
      pwr_meta                <= 1'b0;
      pwr_sync                <= 1'b0;
      driver_module_present_o <= 1'b0;
      overpressure_fault_o    <= 1'b0;
      pressure_feedback_o     <= '0;
    end else if (ce_i) begin
      ins_meta                <= module_inserted_i;
      ins_sync                <= ins_meta;
      pwr_meta                <= module_powered_i;
      pwr_sync                <= pwr_meta;
      driver_module_present_o <= ins_sync && pwr_sync; // see R17
      // set wins over a clear in the same cycle, see R6 R7
      overpressure_fault_o    <= over_limit || (overpressure_fault_o && !overpressure_clear_i);
      pressure_feedback_o     <= fb_value;
    end
  end

  for (genvar v = 0; v < VALVES; v++) begin : g_valve
    valve_cfg_t         cfg;
    logic signed [31:0] integ_acc;
    logic signed [15:0] pv_prev;
    logic [31:0]        pwm_acc;

    assign cfg = valve_cfg_i[v];

    // only the selected valve runs its loop, see R1
    wire selected = (int'(loop_target_select_i) == v);
    // zero gain kills every term, see R12
    wire loop_run = fb_valid && selected && (cfg.prop_gain != 16'sh0000);
    wire integ_on = loop_run && (cfg.integral_time != 16'h0000);

    // signed product keeps the error sign, see R13
    wire signed [16:0] err      = 17'(pressure_target_i) - 17'(fb_value);
    wire signed [32:0] prop_raw = err * cfg.prop_gain;
    wire signed [31:0] prop_sc  = 32'(prop_raw >>> GAIN_FRAC);
    wire signed [31:0] prop_term = loop_run ? prop_sc : 32'sh0000_0000;

    // integral time in sample periods; smaller divisor gives stronger action, see R14
    // divider is combinational: area traded for a one-tick update
    wire signed [31:0] next_integ = integ_acc + prop_sc;
    wire signed [31:0] ti_div     = $signed({16'h0000, cfg.integral_time});
    wire signed [31:0] integ_term = integ_on ? integ_acc / ti_div : 32'sh0000_0000;

    wire signed [16:0] pv_delta   = 17'(pv_prev) - 17'(fb_value);
    wire signed [32:0] deriv_raw  = pv_delta * cfg.prop_gain;
    wire signed [16:0] td_s       = $signed({1'b0, cfg.deriv_time});
    wire signed [49:0] deriv_full = (deriv_raw >>> GAIN_FRAC) * td_s;
    wire signed [31:0] deriv_term = loop_run ? 32'(deriv_full >>> GAIN_FRAC) : 32'sh0000_0000;

    // clamp before feed forward, see R19
    wire signed [33:0] pid_sum = 34'(prop_term) + 34'(integ_term) + 34'(deriv_term);
    wire signed [16:0] pid_clamped =
      (pid_sum > 34'(cfg.loop_out_max)) ? 17'(cfg.loop_out_max) :
      (pid_sum < 34'(cfg.loop_out_min)) ? 17'(cfg.loop_out_min) : 17'(pid_sum);
    wire signed [17:0] loop_duty = 18'(pid_clamped) + 18'(cfg.feed_forward);

    // manual wins, else loop when selected, else fixed duty, see R2 R3 R21
    wire signed [17:0] manual_s = $signed({2'b00, cfg.manual_duty});
    wire signed [17:0] fixed_s  = $signed({2'b00, cfg.non_loop_duty});
    wire signed [17:0] wanted   = cfg.manual_override ? manual_s : selected ? loop_duty : fixed_s;

    // coil current cap from supply mV and coil resistance, see R8
    wire [31:0] cap_raw = (supply_voltage_meas_i == 16'h0000) ? 32'(DUTY_FULL) :
      (32'(CURRENT_MAX_MA) * 32'(cfg.coil_resist_mohm)) / 32'(supply_voltage_meas_i);
    wire [15:0] cap_duty = (cap_raw > 32'(DUTY_FULL)) ? 16'(DUTY_FULL) : cap_raw[15:0];
    // user cap only matters when lower, see R20
    wire [15:0] limit = (cfg.user_max_duty < cap_duty) ? cfg.user_max_duty : cap_duty;
    wire signed [17:0] limit_s = $signed({2'b00, limit});
    wire [15:0] next_duty = (wanted < 0) ? 16'h0000 : (wanted > limit_s) ? limit : 16'(wanted);

    always_ff @(posedge clock_i) begin
      if (srst_i) begin
        integ_acc       <= '0;
        pv_prev         <= '0;
        valve_stat_o[v] <= '0;
      end else if (ce_i && tick) begin
        integ_acc       <= integ_on ? next_integ : 32'sh0000_0000;
        pv_prev         <= fb_value;
        // terms kept apart for status, see R16
        valve_stat_o[v] <= '{prop_term, integ_term, deriv_term, next_duty, cap_duty};
      end
    end

    // cap reapplied live: supply can rise between samples, see R8
    wire [15:0] live_duty = (valve_stat_o[v].duty > limit) ? limit : valve_stat_o[v].duty;
    wire [31:0] on_time   = 32'(live_duty) * 32'(PWM_STEP);
    wire [31:0] acc_sum   = pwm_acc + 32'(cfg.pwm_freq);
    wire        pwm_wrap  = (acc_sum >= 32'(CLK_HZ));

    // phase accumulator in hertz per clock, see R11
    always_ff @(posedge clock_i) begin
      if (srst_i) begin
        pwm_acc <= '0;
      end else if (ce_i) begin
        pwm_acc <= pwm_wrap ? acc_sum - 32'(CLK_HZ) : acc_sum;
      end
    end

    assign ch_drive[v] = (pwm_acc < on_time);
  end

  // fault and enables gate the channels, see R5 R10
  assign drive_en = {relief_valve_drive_enable_i, inlet_valve_drive_enable_i};
  assign gated    = ch_drive & drive_en & {2{!overpressure_fault_o}};
  // partner channels only follow when locked, see R9
  assign next_low_side = {channel_lock_i & gated[RELIEF], gated[RELIEF],
                          channel_lock_i & gated[INLET], gated[INLET]};

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      low_side_o <= 4'h0;
    end else if (ce_i) begin
      low_side_o <= next_low_side;
    end
  end

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);

  fault_sticky_a: assert property ( // see R6
    overpressure_fault_o && !overpressure_clear_i |=> overpressure_fault_o
  ) else $error("fault flag dropped without clear");

  fault_trip_a: assert property ( // see R5
    ce_i && over_limit |=> overpressure_fault_o
  ) else $error("over-pressure did not set fault");

  fault_clear_a: assert property ( // see R7
    ce_i && overpressure_clear_i && !over_limit |=> !overpressure_fault_o
  ) else $error("clear request did not reset fault");

  drive_off_a: assert property ( // see R5
    ce_i && overpressure_fault_o |=> low_side_o == 4'h0
  ) else $error("channels driven during fault");

  pair_lock_a: assert property ( // see R9
    ce_i && channel_lock_i |=> (low_side_o[1] == low_side_o[0]) && (low_side_o[3] == low_side_o[2])
  ) else $error("locked pair differs");

  inlet_gate_a: assert property ( // see R10
    ce_i && !inlet_valve_drive_enable_i |=> !low_side_o[0] && !low_side_o[1]
  ) else $error("inlet channel on while disabled");

  relief_idle_a: assert property ( // see R2
    ce_i && tick && loop_target_select_i == INLET_LOOP_MODE |=>
      valve_stat_o[RELIEF].prop_term == 0 && valve_stat_o[RELIEF].integ_term == 0
      && valve_stat_o[RELIEF].deriv_term == 0
  ) else $error("relief loop active in inlet mode");

  inlet_idle_a: assert property ( // see R3
    ce_i && tick && loop_target_select_i == RELIEF_LOOP_MODE |=>
      valve_stat_o[INLET].prop_term == 0 && valve_stat_o[INLET].integ_term == 0
      && valve_stat_o[INLET].deriv_term == 0
  ) else $error("inlet loop active in relief mode");

  gain_zero_a: assert property ( // see R12
    ce_i && tick && valve_cfg_i[INLET].prop_gain == 0 |=>
      valve_stat_o[INLET].prop_term == 0 && valve_stat_o[INLET].integ_term == 0
  ) else $error("terms nonzero with zero gain");

  integ_off_a: assert property ( // see R14
    ce_i && tick && valve_cfg_i[INLET].integral_time == 0 |=> valve_stat_o[INLET].integ_term == 0
  ) else $error("integral active with zero time");

  duty_cap_a: assert property ( // see R8
    valve_stat_o[INLET].duty <= valve_stat_o[INLET].cap_duty
  ) else $error("inlet duty above current cap");

  present_a: assert property ( // see R17
    ce_i && !(ins_sync && pwr_sync) |=> !driver_module_present_o
  ) else $error("module present without insert and power");

  relief_gate_a: assert property ( // see R10
    ce_i && !relief_valve_drive_enable_i |=> !low_side_o[2] && !low_side_o[3]
  ) else $error("relief channel on while disabled");

  lock_split_a: assert property ( // see R9
    ce_i && !channel_lock_i |=> !low_side_o[1] && !low_side_o[3]
  ) else $error("partner channel on while unlocked");

  present_rise_a: assert property ( // see R17
    ce_i && ins_sync && pwr_sync |=> driver_module_present_o
  ) else $error("module present not raised");

  fb_none_a: assert property ( // see R4
    ce_i && !fb_valid |=> pressure_feedback_o == 16'sh0000
  ) else $error("feedback shown with no source");

  no_source_trip_a: assert property ( // see R4
    ce_i && !fb_valid && !overpressure_fault_o |=> !overpressure_fault_o
  ) else $error("fault raised with no feedback source");

  // status may only move on the sample strobe
  inlet_hold_a: assert property ( // see R22
    ce_i && !tick |=> $stable(valve_stat_o[INLET])
  ) else $error("inlet status moved between samples");

  relief_hold_a: assert property ( // see R22
    ce_i && !tick |=> $stable(valve_stat_o[RELIEF])
  ) else $error("relief status moved between samples");

  single_loop_a: assert property ( // see R1
    ce_i && tick |=> valve_stat_o[INLET].prop_term == 0 || valve_stat_o[RELIEF].prop_term == 0
  ) else $error("both valve loops active");

  relief_fixed_a: assert property ( // see R2
    ce_i && tick && loop_target_select_i == INLET_LOOP_MODE && !valve_cfg_i[RELIEF].manual_override
      && valve_cfg_i[RELIEF].non_loop_duty <= g_valve[RELIEF].limit
      |=> valve_stat_o[RELIEF].duty == $past(valve_cfg_i[RELIEF].non_loop_duty)
  ) else $error("relief fixed duty not applied");

  inlet_fixed_a: assert property ( // see R3
    ce_i && tick && loop_target_select_i == RELIEF_LOOP_MODE && !valve_cfg_i[INLET].manual_override
      && valve_cfg_i[INLET].non_loop_duty <= g_valve[INLET].limit
      |=> valve_stat_o[INLET].duty == $past(valve_cfg_i[INLET].non_loop_duty)
  ) else $error("inlet fixed duty not applied");

  manual_hold_a: assert property ( // see R21
    ce_i && tick && valve_cfg_i[INLET].manual_override
      && valve_cfg_i[INLET].manual_duty <= g_valve[INLET].limit
      |=> valve_stat_o[INLET].duty == $past(valve_cfg_i[INLET].manual_duty)
  ) else $error("manual duty not applied");

  relief_gain_zero_a: assert property ( // see R12
    ce_i && tick && valve_cfg_i[RELIEF].prop_gain == 0 |=>
      valve_stat_o[RELIEF].prop_term == 0 && valve_stat_o[RELIEF].integ_term == 0
  ) else $error("relief terms nonzero with zero gain");

  relief_integ_off_a: assert property ( // see R14
    ce_i && tick && valve_cfg_i[RELIEF].integral_time == 0 |=> valve_stat_o[RELIEF].integ_term == 0
  ) else $error("relief integral active with zero time");

  trip_c: cover property (ce_i && over_limit ##1 overpressure_fault_o);
  clear_c: cover property (overpressure_fault_o ##1 !overpressure_fault_o);
  relief_mode_c: cover property (ce_i && tick && loop_target_select_i == RELIEF_LOOP_MODE);
  lock_drive_c: cover property (channel_lock_i && low_side_o[0] && low_side_o[1]);
  integ_c: cover property (ce_i && tick && g_valve[INLET].integ_on);
endmodule

// *** valve_sensor_model.sv ***
// rail pressure sensor stand-in feeding the four analog inputs
module valve_sensor_model (
  input  wire logic               clock_i,
  input  wire logic [1:0]         sensor_ch_i,
  input  wire logic signed [15:0] pressure_i,
  output logic signed [15:0]      analog_in_o [4]
);
  timeunit 1ns;
  timeprecision 1ps;
  // unwired inputs wander every cycle so a wrong select cannot match by luck
  logic [15:0] wander = 16'h0000;
  always @(posedge clock_i) begin
    wander <= wander + 16'h1235;
  end
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      // sensor already delivers bar, no scaling here
      analog_in_o[k] = (k == int'(sensor_ch_i)) ? pressure_i : $signed(wander ^ 16'(k));
    end
  end
endmodule

// *** tb_rail_pressure_loop_ctrl.sv ***
// self-checking bench for the rail pressure loop controller
module tb_rail_pressure_loop_ctrl;
  import rail_pressure_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clock_i = 1'b0;
  logic               srst_i  = 1'b1;
  logic signed [15:0] ain [4];
  pressure_sel_t      sel     = SEL_AI0;
  logic [1:0]         sensor_ch = 2'h0;
  logic signed [15:0] pressure = 16'h005a;
  logic signed [15:0] target  = 16'h0064;
  logic signed [15:0] limit   = 16'h00c8;
  logic               clear   = 1'b0;
  loop_target_t       mode    = INLET_LOOP_MODE;
  valve_cfg_t         cfg [VALVES];
  logic [15:0]        supply  = 16'h2ee0;
  logic               inlet_en = 1'b1;
  logic               relief_en = 1'b1;
  logic               lock    = 1'b1;
  logic               inserted = 1'b0;
  logic               powered = 1'b0;
  logic [3:0]         low_side;
  logic               fault;
  logic               present;
  logic signed [15:0] feedback;
  valve_stat_t        stat [VALVES];
  int                 n_mismatch = 0;
  int                 checked = 0;
  localparam int unsigned TICKS = 16;
  logic               ce      = 1'b1;
  logic [31:0]        base;
  int                 hi;

  always #2 clock_i = ~clock_i;

  valve_sensor_model sensor (.clock_i(clock_i), .sensor_ch_i(sensor_ch), .pressure_i(pressure), .analog_in_o(ain));

  rail_pressure_loop_ctrl #(.SAMPLE_CYCLES_P(TICKS)) dut (
    .clock_i(clock_i), .srst_i(srst_i), .ce_i(ce), .analog_in_i(ain),
    .pressure_input_select_i(sel), .pressure_target_i(target), .overpressure_limit_i(limit),
    .overpressure_clear_i(clear), .loop_target_select_i(mode), .valve_cfg_i(cfg),
    .supply_voltage_meas_i(supply), .inlet_valve_drive_enable_i(inlet_en),
    .relief_valve_drive_enable_i(relief_en), .channel_lock_i(lock), .module_inserted_i(inserted),
    .module_powered_i(powered), .low_side_o(low_side), .overpressure_fault_o(fault),
    .driver_module_present_o(present), .pressure_feedback_o(feedback), .valve_stat_o(stat));

  task automatic check_val(input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  // integral and derivative stay zero: Ti and Td are zero at every call of this task
  task automatic chk_stat(input int v, input logic [15:0] duty, input logic [31:0] p);
    cyc(40);
    check_val({16'h0000, duty}, {16'h0000, stat[v].duty});
    check_val(p, stat[v].prop_term);
    check_val(32'h0000_0000, stat[v].integ_term);
    check_val(32'h0000_0000, stat[v].deriv_term);
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // run needs about five thousand cycles; four times that means a hang
  initial begin
    repeat (20000) @(posedge clock_i);
    n_mismatch++;
    finish_test();
  end

  initial begin
    for (int v = 0; v < VALVES; v++) begin
      // integral time never negative, the field is unsigned
      cfg[v] = '{16'h03e8, 16'h0000, 16'h0000, 16'h0000, 16'h03e8, 16'hfc18, 16'h03e8, 16'h03e8, 1'b0,
                 16'h0000, 16'h03e8, 16'h1f40};
    end
    cyc(10);
    srst_i = 1'b0;
    inserted = 1'b1;
    cyc(5);
    check_val(32'h0000_0000, {31'h0, present});
    powered = 1'b1;
    cyc(5);
    check_val(32'h0000_0001, {31'h0, present});
    end_test("present");
    for (int c = 0; c < 4; c++) begin
      sensor_ch = 2'(c);
      sel = pressure_sel_t'(3'(c + 1));
      cyc(3);
      check_val(32'h0000_005a, 32'(feedback));
    end
    sel = SEL_NONE;
    cyc(3);
    check_val(32'h0000_0000, 32'(feedback));
    sel = pressure_sel_t'(3'(4));
    end_test("select");
    cyc(40);
    check_val(32'h0000_000f, {28'h0, low_side});
    inlet_en = 1'b0;
    cyc(3);
    check_val(32'h0000_000c, {28'h0, low_side});
    inlet_en = 1'b1;
    lock = 1'b0;
    cyc(3);
    check_val(32'h0000_0005, {28'h0, low_side});
    lock = 1'b1;
    relief_en = 1'b0;
    cyc(3);
    check_val(32'h0000_0003, {28'h0, low_side});
    relief_en = 1'b1;
    end_test("drive");
    ce = 1'b0;
    pressure = 16'h00c9;
    cyc(3);
    check_val(32'h0000_0000, {31'h0, fault});
    ce = 1'b1;
    cyc(3);
    check_val(32'h0000_0001, {31'h0, fault});
    check_val(32'h0000_0000, {28'h0, low_side});
    pressure = 16'h005a;
    cyc(5);
    check_val(32'h0000_0001, {31'h0, fault});
    check_val(32'h0000_0000, {28'h0, low_side});
    clear = 1'b1;
    cyc(1);
    clear = 1'b0;
    cyc(3);
    check_val(32'h0000_0000, {31'h0, fault});
    cyc(3);
    check_val(32'h0000_000f, {28'h0, low_side});
    end_test("fault");
    cfg[0].feed_forward = 16'h01f4;
    cfg[1].prop_gain = 16'h0100;
    chk_stat(0, 16'h01f4, 32'h0000_0000);
    chk_stat(1, 16'h03e8, 32'h0000_0000);
    cfg[0].prop_gain = 16'h0100;
    chk_stat(0, 16'h01fe, 32'h0000_000a);
    cfg[0].prop_gain = 16'hff00;
    chk_stat(0, 16'h01ea, 32'hffff_fff6);
    cfg[0].prop_gain = 16'h0100;
    cfg[0].loop_out_max = 16'h0005;
    chk_stat(0, 16'h01f9, 32'h0000_000a);
    end_test("inlet loop");
    mode = RELIEF_LOOP_MODE;
    cfg[0].non_loop_duty = 16'h00fa;
    cfg[1].feed_forward = 16'h01f4;
    chk_stat(0, 16'h00fa, 32'h0000_0000);
    chk_stat(1, 16'h01fe, 32'h0000_000a);
    mode = INLET_LOOP_MODE;
    end_test("relief loop");
    cfg[0].integral_time = 16'h0001;
    cyc(3 * TICKS);
    base = stat[0].integ_term;
    cyc(TICKS);
    check_val(base + 32'h0000_000a, stat[0].integ_term);
    cfg[0].integral_time = 16'h0002;
    cyc(3 * TICKS);
    base = stat[0].integ_term;
    cyc(TICKS);
    check_val(base + 32'h0000_0005, stat[0].integ_term);
    cfg[0].integral_time = 16'h0000;
    end_test("integral");
    cfg[0].prop_gain = 16'h0000;
    cfg[0].feed_forward = 16'h0320;
    cfg[0].coil_resist_mohm = 16'h07d0;
    chk_stat(0, 16'h01f4, 32'h0000_0000);
    check_val(32'h0000_01f4, {16'h0000, stat[0].cap_duty});
    cfg[0].user_max_duty = 16'h012c;
    chk_stat(0, 16'h012c, 32'h0000_0000);
    cfg[0].manual_override = 1'b1;
    cfg[0].manual_duty = 16'h014d;
    cfg[0].user_max_duty = 16'h03e8;
    chk_stat(0, 16'h014d, 32'h0000_0000);
    end_test("limits");
    cfg[1].non_loop_duty = 16'h01f4;
    cfg[1].pwm_freq = 16'hf424;
    cyc(40);
    hi = 0;
    repeat (4000) begin
      @(negedge clock_i);
      hi += int'(low_side[2]);
    end
    // 62500 hz divides the clock exactly: 4000-cycle period, half of it on
    check_val(32'h0000_07d0, 32'(hi));
    end_test("pwm");
    finish_test();
  end
endmodule
